// *** logic/slot_bw_pkg.sv ***
// slot_bw_pkg: offsets, field layout and reset values of the slot/bandwidth register bank
// assumes a 32-bit apb slave with word-aligned registers
package slot_bw_pkg;
    localparam logic [11:0] off_link_status = 12'h0050;
    localparam logic [11:0] off_slot_cap = 12'h0054;
    localparam logic [11:0] off_irq_status = 12'h0060;
    localparam logic [11:0] off_irq_mask = 12'h0064;
    localparam logic [11:0] off_port_ctrl = 12'h0068;
    localparam logic [11:0] off_loader = 12'h006c;
    localparam logic [11:0] off_msg_count = 12'h0070;
    localparam int bw_mgmt_bit = 14;
    localparam int auto_bw_bit = 15;
    localparam int cap_lo_bit = 0;
    localparam int cap_hi_bit = 6;
    localparam int power_limit_value_lo = 7;
    localparam int power_limit_value_hi = 14;
    localparam int power_limit_scale_lo = 15;
    localparam int power_limit_scale_hi = 16;
    localparam int eip_bit = 17;
    localparam int no_cmd_complete_support_bit = 18;
    localparam int slotnum_lo = 19;
    localparam int slotnum_hi = 31;
    // writable power limit bits 16:7
    localparam logic [31:0] slot_cap_rw_mask = 32'h0001_ff80;
    // loader-only bits: presence, hot-plug, interlock, slot number
    localparam logic [31:0] slot_cap_load_mask = 32'hfffa_007f;
    localparam logic [31:0] slot_cap_reset = 32'h0000_0000;
    localparam logic [1:0] irq_bw_mgmt = 2'b01;
    localparam logic [1:0] irq_auto_bw = 2'b10;
    localparam logic [1:0] irq_reset = 2'b00;
    localparam logic [15:0] msg_count_reset = 16'h0000;
    localparam logic [31:0] read_zero = 32'h0000_0000;
    typedef enum logic [2:0] {
        msg_idle = 3'b001,
        msg_send = 3'b010,
        msg_pend = 3'b100
    } msg_state_e;
endpackage

// *** logic/bw_event_detect.sv ***
// bw_event_detect: turns link-layer indications into bandwidth event pulses
// assumes all inputs are from logic on pclk
`timescale 1ns/1ps
`default_nettype none
module bw_event_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic retrain_done,
    input wire logic dl_up,
    input wire logic phy_fix_change,
    input wire logic phy_auto_change,
    input wire logic partner_change,
    input wire logic partner_auto,
    output logic bw_mgmt_event,
    output logic auto_bw_event,
    output logic dl_up_rise
);
    import slot_bw_pkg::*;
    logic dl_up_q, dl_up_d;
    logic down_seen_q, down_seen_d;

    always_comb begin
        dl_up_d = dl_up;
        // remembers a dl_down visit since the last retrain finished
        down_seen_d = down_seen_q;
        if (!dl_up) begin
            down_seen_d = 1'b1;
        end else if (retrain_done) begin
            down_seen_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dl_up_q <= 1'b0;
            down_seen_q <= 1'b0;
        end else begin
            dl_up_q <= dl_up_d;
            down_seen_q <= down_seen_d;
        end
    end

    assign bw_mgmt_event = (retrain_done && dl_up && !down_seen_q)
        || phy_fix_change
        || (partner_change && !partner_auto);
    assign auto_bw_event = phy_auto_change
        || (partner_change && partner_auto);
    assign dl_up_rise = dl_up && !dl_up_q;
endmodule
`default_nettype wire

// *** logic/power_msg_gen.sv ***
// power_msg_gen: issues set-slot-power-limit requests with valid/ready
// assumes the transmit side holds ready low while busy
`timescale 1ns/1ps
`default_nettype none
module power_msg_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trigger,
    input wire logic [7:0] value,
    input wire logic [1:0] scale,
    output logic msg_valid,
    input wire logic msg_ready,
    output logic [7:0] msg_value,
    output logic [1:0] msg_scale,
    output logic sent
);
    import slot_bw_pkg::*;
    msg_state_e state_q, state_d;
    logic [7:0] value_q, value_d;
    logic [1:0] scale_q, scale_d;

    always_comb begin
        state_d = state_q;
        value_d = value_q;
        scale_d = scale_q;
        case (state_q)
            msg_idle: begin
                if (trigger) begin
                    state_d = msg_send;
                    value_d = value;
                    scale_d = scale;
                end
            end
            msg_send: begin
                // a trigger while waiting replaces the fields; one in the accepting cycle queues one more
                if (msg_ready) begin
                    state_d = trigger ? msg_pend : msg_idle;
                end else if (trigger) begin
                    value_d = value;
                    scale_d = scale;
                end
            end
            msg_pend: begin
                state_d = msg_send;
                value_d = value;
                scale_d = scale;
            end
            default: state_d = msg_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= msg_idle;
            value_q <= 8'h00;
            scale_q <= 2'h0;
        end else begin
            state_q <= state_d;
            value_q <= value_d;
            scale_q <= scale_d;
        end
    end

    assign msg_valid = (state_q == msg_send);
    assign msg_value = value_q;
    assign msg_scale = scale_q;
    assign sent = msg_valid && msg_ready;
endmodule
`default_nettype wire

// *** logic/slot_bw_regs.sv ***
// slot_bw_regs: link bandwidth status flags and slot capabilities for one switch port
// assumes an apb master on pclk and link/phy indications on the same clock
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module slot_bw_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slot_implemented,
    input wire logic bw_notify_capable,
    input wire logic is_upstream_port,
    input wire logic link_retrain_request,
    input wire logic retrain_done,
    input wire logic dl_up,
    input wire logic phy_fix_change,
    input wire logic phy_auto_change,
    input wire logic partner_change,
    input wire logic partner_auto,
    input wire logic autonomous_bw_irq_enable,
    output logic msg_valid,
    input wire logic msg_ready,
    output logic [7:0] msg_value,
    output logic [1:0] msg_scale,
    output logic irq
);
    import slot_bw_pkg::*;

    logic bw_mgmt_status_flag_q, bw_mgmt_status_flag_d;
    logic autonomous_bw_status_flag_q, autonomous_bw_status_flag_d;
    logic [31:0] slot_capabilities_reg_q, slot_capabilities_reg_d;
    logic [1:0] irq_status_q, irq_status_d;
    logic [1:0] irq_mask_q, irq_mask_d;
    logic loader_en_q, loader_en_d;
    logic [15:0] msg_count_q, msg_count_d;
    logic [31:0] prdata_q, prdata_d;
    logic bw_mgmt_event, auto_bw_event, dl_up_rise, sent;
    logic wr, rd, flags_live, cap_write, mapped;
    logic [31:0] slot_view, link_view, slot_next;

    bw_event_detect u_detect (
        .pclk(pclk),
        .presetn(presetn),
        .retrain_done(retrain_done),
        .dl_up(dl_up),
        .phy_fix_change(phy_fix_change),
        .phy_auto_change(phy_auto_change),
        .partner_change(partner_change),
        .partner_auto(partner_auto),
        .bw_mgmt_event(bw_mgmt_event),
        .auto_bw_event(auto_bw_event),
        .dl_up_rise(dl_up_rise)
    );

    power_msg_gen u_msg (
        .pclk(pclk),
        .presetn(presetn),
        .trigger((wr && cap_write && slot_implemented) || dl_up_rise),
        .value(slot_next[power_limit_value_hi:power_limit_value_lo]),
        .scale(slot_next[power_limit_scale_hi:power_limit_scale_lo]),
        .msg_valid(msg_valid),
        .msg_ready(msg_ready),
        .msg_value(msg_value),
        .msg_scale(msg_scale),
        .sent(sent)
    );

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // writes complete in their first access cycle; reads take one wait state
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign cap_write = hit(paddr, off_slot_cap);
    assign mapped = hit(paddr, off_link_status) || cap_write || hit(paddr, off_irq_status)
        || hit(paddr, off_irq_mask) || hit(paddr, off_port_ctrl) || hit(paddr, off_loader)
        || hit(paddr, off_msg_count);
    assign flags_live = bw_notify_capable && !is_upstream_port;
    // message must carry the value being written, not the one it replaces
    assign slot_next = slot_implemented ? slot_capabilities_reg_d : read_zero;

    always_comb begin
        slot_view = slot_implemented ? slot_capabilities_reg_q : read_zero;
        slot_view[no_cmd_complete_support_bit] = 1'b0;
        link_view = read_zero;
        link_view[bw_mgmt_bit] = bw_mgmt_status_flag_q;
        link_view[auto_bw_bit] = autonomous_bw_status_flag_q;
    end

    always_comb begin
        bw_mgmt_status_flag_d = bw_mgmt_status_flag_q;
        autonomous_bw_status_flag_d = autonomous_bw_status_flag_q;
        // clear first, then set, so a same-cycle event wins
        if (wr && hit(paddr, off_link_status)) begin
            if (pwdata[bw_mgmt_bit]) begin
                bw_mgmt_status_flag_d = 1'b0;
            end
            if (pwdata[auto_bw_bit]) begin
                autonomous_bw_status_flag_d = 1'b0;
            end
        end
        if (bw_mgmt_event) begin
            bw_mgmt_status_flag_d = 1'b1;
        end
        if (auto_bw_event) begin
            autonomous_bw_status_flag_d = 1'b1;
        end
        if (!flags_live) begin
            bw_mgmt_status_flag_d = 1'b0;
            autonomous_bw_status_flag_d = 1'b0;
        end
    end

    always_comb begin
        slot_capabilities_reg_d = slot_capabilities_reg_q;
        if (wr && cap_write && slot_implemented) begin
            // power limit fields take software writes; loadable ones only via loader
            slot_capabilities_reg_d = (slot_capabilities_reg_q & ~slot_cap_rw_mask)
                | (pwdata & slot_cap_rw_mask);
            if (loader_en_q) begin
                slot_capabilities_reg_d = (slot_capabilities_reg_d & ~slot_cap_load_mask)
                    | (pwdata & slot_cap_load_mask);
            end
        end
    end

    always_comb begin
        irq_status_d = irq_status_q;
        irq_mask_d = irq_mask_q;
        loader_en_d = loader_en_q;
        msg_count_d = msg_count_q;
        if (wr && hit(paddr, off_irq_status)) begin
            irq_status_d = irq_status_q & ~pwdata[1:0];
        end
        if (wr && hit(paddr, off_irq_mask)) begin
            irq_mask_d = pwdata[1:0];
        end
        if (wr && hit(paddr, off_loader)) begin
            // loader window; a limitation: software could reopen it
            loader_en_d = pwdata[0];
        end
        if (bw_mgmt_event && flags_live) begin
            irq_status_d = irq_status_d | irq_bw_mgmt;
        end
        if (auto_bw_event && flags_live) begin
            irq_status_d = irq_status_d | irq_auto_bw;
        end
        if (sent) begin
            msg_count_d = msg_count_q + 16'h0001;
        end
    end

    always_comb begin
        prdata_d = prdata_q;
        if (rd) begin
            if (hit(paddr, off_link_status)) begin
                prdata_d = link_view;
            end else if (cap_write) begin
                prdata_d = slot_view;
            end else if (hit(paddr, off_irq_status)) begin
                prdata_d = {30'h0000_0000, irq_status_q};
            end else if (hit(paddr, off_irq_mask)) begin
                prdata_d = {30'h0000_0000, irq_mask_q};
            end else if (hit(paddr, off_port_ctrl)) begin
                prdata_d = {28'h000_0000, is_upstream_port, bw_notify_capable,
                    slot_implemented, link_retrain_request};
            end else if (hit(paddr, off_loader)) begin
                prdata_d = {31'h0000_0000, loader_en_q};
            end else if (hit(paddr, off_msg_count)) begin
                prdata_d = {16'h0000, msg_count_q};
            end else begin
                prdata_d = read_zero;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bw_mgmt_status_flag_q <= 1'b0;
            autonomous_bw_status_flag_q <= 1'b0;
            slot_capabilities_reg_q <= slot_cap_reset;
            irq_status_q <= irq_reset;
            irq_mask_q <= irq_reset;
            loader_en_q <= 1'b1;
            msg_count_q <= msg_count_reset;
            prdata_q <= read_zero;
        end else begin
            bw_mgmt_status_flag_q <= bw_mgmt_status_flag_d;
            autonomous_bw_status_flag_q <= autonomous_bw_status_flag_d;
            slot_capabilities_reg_q <= slot_capabilities_reg_d;
            irq_status_q <= irq_status_d;
            irq_mask_q <= irq_mask_d;
            loader_en_q <= loader_en_d;
            msg_count_q <= msg_count_d;
            prdata_q <= prdata_d;
        end
    end

    // read data is registered, so prdata is valid one edge after the access edge;
    // pready therefore waits one cycle on reads
    logic rd_wait_q, rd_wait_d;
    always_comb begin
        rd_wait_d = rd && !rd_wait_q;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_wait_q <= 1'b0;
        end else begin
            rd_wait_q <= rd_wait_d;
        end
    end
    assign pready = pwrite ? 1'b1 : rd_wait_q;
    assign pslverr = psel && penable && pready && !mapped;
    assign prdata = prdata_q;
    // autonomous event also gated by its own enable bit
    assign irq = |(irq_status_q & irq_mask_q)
        || (autonomous_bw_status_flag_q && autonomous_bw_irq_enable && flags_live);

    property p_flag_clear;
        @(posedge pclk) disable iff (!presetn)
        (wr && hit(paddr, off_link_status) && pwdata[bw_mgmt_bit] && !bw_mgmt_event)
            |=> !bw_mgmt_status_flag_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("bw flag not cleared");

    property p_flag_keep;
        @(posedge pclk) disable iff (!presetn)
        (wr && hit(paddr, off_link_status) && !pwdata[auto_bw_bit] && flags_live)
            |=> (autonomous_bw_status_flag_q || !$past(autonomous_bw_status_flag_q));
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost on zero write");

    property p_upstream;
        @(posedge pclk) disable iff (!presetn)
        (is_upstream_port && $past(is_upstream_port)) |-> (link_view == read_zero);
    endproperty
    a_upstream: assert property (p_upstream) else $error("flags alive in upstream port");

    property p_bw_set;
        @(posedge pclk) disable iff (!presetn)
        (bw_mgmt_event && flags_live) |=> bw_mgmt_status_flag_q;
    endproperty
    a_bw_set: assert property (p_bw_set) else $error("bw flag not set");

    property p_partner_nonauto;
        @(posedge pclk) disable iff (!presetn)
        (partner_change && !partner_auto && flags_live) |=> bw_mgmt_status_flag_q;
    endproperty
    a_partner_nonauto: assert property (p_partner_nonauto) else $error("partner change lost");

    property p_auto_set;
        @(posedge pclk) disable iff (!presetn)
        ((phy_auto_change || (partner_change && partner_auto)) && flags_live)
            |=> autonomous_bw_status_flag_q;
    endproperty
    a_auto_set: assert property (p_auto_set) else $error("autonomous flag not set");

    property p_flags_dead;
        @(posedge pclk) disable iff (!presetn)
        !flags_live |=> (link_view == read_zero);
    endproperty
    a_flags_dead: assert property (p_flags_dead) else $error("flags alive without capability");

    property p_no_slot;
        @(posedge pclk) disable iff (!presetn)
        (rd && cap_write && !slot_implemented) |=> (prdata == read_zero);
    endproperty
    a_no_slot: assert property (p_no_slot) else $error("slot fields visible");

    property p_cap_write;
        @(posedge pclk) disable iff (!presetn)
        (wr && cap_write && slot_implemented)
            |=> ((slot_capabilities_reg_q & slot_cap_rw_mask) == ($past(pwdata) & slot_cap_rw_mask));
    endproperty
    a_cap_write: assert property (p_cap_write) else $error("power limit not written");

    property p_no_cmd_complete_support;
        @(posedge pclk) disable iff (!presetn)
        rd ##1 rd_wait_q |-> !prdata[no_cmd_complete_support_bit];
    endproperty
    a_no_cmd_complete_support: assert property (p_no_cmd_complete_support) else $error("no_cmd_complete_support not zero");

    sequence s_cap_write;
        wr && cap_write && slot_implemented && !msg_valid;
    endsequence
    property p_msg_on_write;
        @(posedge pclk) disable iff (!presetn)
        s_cap_write |=> msg_valid;
    endproperty
    a_msg_on_write: assert property (p_msg_on_write) else $error("no power message");

    property p_msg_hold;
        @(posedge pclk) disable iff (!presetn)
        (msg_valid && !msg_ready) |=> msg_valid;
    endproperty
    a_msg_hold: assert property (p_msg_hold) else $error("message dropped unsent");

    property p_msg_on_up;
        @(posedge pclk) disable iff (!presetn)
        (dl_up && !$past(dl_up) && !msg_valid) |=> msg_valid;
    endproperty
    a_msg_on_up: assert property (p_msg_on_up) else $error("no message on dl_up");

    property p_sw_locked;
        @(posedge pclk) disable iff (!presetn)
        (wr && cap_write && !loader_en_q) |=>
            ((slot_capabilities_reg_q & slot_cap_load_mask)
            == $past(slot_capabilities_reg_q & slot_cap_load_mask));
    endproperty
    a_sw_locked: assert property (p_sw_locked) else $error("loadable field changed");

    property p_auto_irq;
        @(posedge pclk) disable iff (!presetn)
        (autonomous_bw_status_flag_q && autonomous_bw_irq_enable && flags_live) |-> irq;
    endproperty
    a_auto_irq: assert property (p_auto_irq) else $error("missing interrupt");

    property p_auto_status;
        @(posedge pclk) disable iff (!presetn)
        (auto_bw_event && flags_live) |=> ((irq_status_q & irq_auto_bw) == irq_auto_bw);
    endproperty
    a_auto_status: assert property (p_auto_status) else $error("event status not set");
endmodule
`default_nettype wire

// *** test/msg_sink.sv ***
// msg_sink: far-end model that takes set-slot-power-limit messages
// assumes valid/ready on pclk; slow makes ready come and go at random
`timescale 1ns/1ps
`default_nettype none
module msg_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic msg_valid,
    output logic msg_ready,
    input wire logic [7:0] msg_value,
    input wire logic [1:0] msg_scale,
    output logic [7:0] last_value,
    output logic [1:0] last_scale,
    output logic [15:0] count
);
    // ready may drop while valid stands; the sender must hold its beat
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_ready <= 1'b0;
            count <= 16'h0000;
            last_value <= 8'h00;
            last_scale <= 2'h0;
        end else begin
            msg_ready <= slow ? ($urandom_range(3) == 0) : 1'b1;
            if (msg_valid && msg_ready) begin
                count <= count + 16'h0001;
                last_value <= msg_value;
                last_scale <= msg_scale;
            end
        end
    end
endmodule
`default_nettype wire

// *** test/pcie_slot_cap_link_bw_status_bench.sv ***
// pcie_slot_cap_link_bw_status_bench: self-checking bench for slot_bw_regs
// assumes msg_sink as the far end of the power message port
`timescale 1ns/1ps
`default_nettype none
module pcie_slot_cap_link_bw_status_bench;
    import slot_bw_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, wr_val, exp;
    logic pready, pslverr, err, msg_valid, msg_ready, irq;
    logic slot_impl = 1, bw_cap = 1, upstream = 0, retrain_req = 0, dl_up = 0, irq_en = 0;
    logic [4:0] ev = 5'h00;
    logic [7:0] msg_value, got_value;
    logic [1:0] msg_scale, got_scale;
    logic [15:0] sink_count;
    logic [4:0] kinds [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h18};
    int n_fail = 0, compares = 0;
    always #10 pclk = ~pclk;
    slot_bw_regs i_slot_bw_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slot_implemented(slot_impl),
        .bw_notify_capable(bw_cap), .is_upstream_port(upstream),
        .link_retrain_request(retrain_req), .retrain_done(ev[0]), .dl_up(dl_up),
        .phy_fix_change(ev[1]), .phy_auto_change(ev[2]), .partner_change(ev[3]),
        .partner_auto(ev[4]), .autonomous_bw_irq_enable(irq_en), .msg_valid(msg_valid),
        .msg_ready(msg_ready), .msg_value(msg_value), .msg_scale(msg_scale), .irq(irq));
    msg_sink i_msg_sink (.pclk(pclk), .presetn(presetn), .slow(slow), .msg_valid(msg_valid),
        .msg_ready(msg_ready), .msg_value(msg_value), .msg_scale(msg_scale),
        .last_value(got_value), .last_scale(got_scale), .count(sink_count));
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, want);
        end
    endtask
    // request held from setup until the edge that sees pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // values read here are those the design sampled at this edge
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [4:0] k);
        @(posedge pclk);
        ev <= k;
        @(posedge pclk);
        ev <= 5'h00;
        @(posedge pclk);
    endtask
    task automatic wait_msg(input logic [15:0] n);
        int t;
        t = 0;
        while (sink_count !== n && t < 100) begin
            t++;
            @(posedge pclk);
        end
        chk({16'h0000, sink_count}, {16'h0000, n});
    endtask
    task automatic chk_irq(input logic want);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, want});
    endtask
    function automatic logic [1:0] exp_flags(input int k, input logic live);
        if (!live) return 2'h0;
        return (k == 2 || k == 4) ? 2'h2 : 2'h1;
    endfunction
    task automatic test_done;
        $display("counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        test_done;
    end
    initial begin
        void'($urandom(41));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, off_link_status, 0);
        chk(rd & 32'h0000_c000, 0);
        apb(0, off_slot_cap, 0);
        chk(rd, slot_cap_reset);
        $display("reset test done");
        dl_up <= 1'b1;
        wait_msg(1);
        chk({got_scale, got_value}, 0);
        for (int i = 0; i < 4; i++) begin
            wr_val = $urandom;
            wr_val[16:15] = i[1:0];
            slow <= i[0];
            apb(1, off_slot_cap, wr_val);
            exp = wr_val & (slot_cap_rw_mask | slot_cap_load_mask);
            wait_msg(16'(i + 2));
            chk({got_scale, got_value}, {exp[16:15], exp[14:7]});
            apb(0, off_slot_cap, 0);
            chk(rd, exp);
        end
        apb(1, off_loader, 0);
        apb(1, off_slot_cap, ~exp);
        exp = (exp & slot_cap_load_mask) | (~exp & slot_cap_rw_mask);
        apb(0, off_slot_cap, 0);
        chk(rd, exp);
        wait_msg(6);
        apb(0, off_msg_count, 0);
        chk({16'h0000, rd[15:0]}, 32'h0000_0006);
        apb(0, 12'hffc, 0);
        chk({rd[30:0], err}, 32'h0000_0001);
        slot_impl <= 1'b0;
        retrain_req <= 1'b1;
        apb(0, off_slot_cap, 0);
        chk(rd, 0);
        apb(1, off_slot_cap, 32'hffff_ffff);
        apb(0, off_port_ctrl, 0);
        chk(rd & 32'h0000_000f, 32'h0000_0005);
        slot_impl <= 1'b1;
        apb(0, off_slot_cap, 0);
        chk(rd, exp);
        wait_msg(6);
        $display("slot capability test done");
        pulse(kinds[0]);
        apb(1, off_link_status, 32'h0000_c000);
        for (int c = 0; c < 3; c++) begin
            bw_cap <= (c != 1);
            upstream <= (c == 2);
            for (int k = 0; k < 5; k++) begin
                pulse(kinds[k]);
                apb(0, off_link_status, 0);
                chk(rd[15:14], exp_flags(k, c == 0));
                apb(1, off_link_status, 0);
                apb(0, off_link_status, 0);
                chk(rd[15:14], exp_flags(k, c == 0));
                apb(1, off_link_status, 32'h0000_c000);
                apb(0, off_link_status, 0);
                chk(rd[15:14], 0);
            end
        end
        bw_cap <= 1'b1;
        upstream <= 1'b0;
        dl_up <= 1'b0;
        repeat (3) @(posedge pclk);
        dl_up <= 1'b1;
        pulse(kinds[0]);
        apb(0, off_link_status, 0);
        chk(rd[15:14], 0);
        $display("bandwidth flag test done");
        apb(1, off_irq_status, 3);
        apb(1, off_irq_mask, 3);
        pulse(kinds[1]);
        chk_irq(1'b1);
        apb(0, off_irq_status, 0);
        chk(rd[1:0], irq_bw_mgmt);
        apb(1, off_irq_status, 3);
        apb(1, off_link_status, 32'h0000_c000);
        chk_irq(1'b0);
        apb(1, off_irq_mask, 0);
        pulse(kinds[2]);
        chk_irq(1'b0);
        irq_en <= 1'b1;
        chk_irq(1'b1);
        apb(1, off_link_status, 32'h0000_c000);
        chk_irq(1'b0);
        $display("interrupt test done");
        test_done;
    end
endmodule
`default_nettype wire
